// *** shared/epm_params.svh ***
/*
  constants for the shared-pin multiplexer: role codes, gpio modes, led timing.
  assumes a 100 MHz core clock.
*/
`ifndef EPM_PARAMS_SVH
`define EPM_PARAMS_SVH

`define EPM_CLK_HZ          100000000
`define EPM_LED_PULSE_MS    80
`define EPM_LED_PULSE_CYC   ((`EPM_CLK_HZ / 1000) * `EPM_LED_PULSE_MS)
`define EPM_ROLE_EEPROM     2'h0
`define EPM_ROLE_GPO        2'h1
`define EPM_ROLE_MON_CTRL   2'h2
`define EPM_ROLE_MON_CLK    2'h3
`define EPM_GPIO_INPUT      2'h0
`define EPM_GPIO_PUSHPULL   2'h1
`define EPM_GPIO_OPENDRAIN  2'h2
`define EPM_NUM_GPIO        3

`endif

// *** shared/epm_pkg.sv ***
/*
  types for the shared-pin multiplexer.
  assumes epm_params.svh for the numeric codes.
*/
package epm_pkg;

  typedef enum logic [1:0] {
    EPM_ROLE_EEPROM   = 2'h0,
    EPM_ROLE_GPO      = 2'h1,
    EPM_ROLE_MON_CTRL = 2'h2,
    EPM_ROLE_MON_CLK  = 2'h3
  } epm_role_t;

  typedef enum logic [1:0] {
    EPM_GPIO_INPUT     = 2'h0,
    EPM_GPIO_PUSHPULL  = 2'h1,
    EPM_GPIO_OPENDRAIN = 2'h2
  } epm_gpio_mode_t;

  typedef struct packed {
    logic speed_10;
    logic link_up;
    logic activity;
    logic full_duplex;
  } epm_phy_status_t;

  typedef struct packed {
    logic o;
    logic oe;
  } epm_pin_drive_t;

  typedef enum logic [1:0] {
    EPM_ACT_IDLE  = 2'h0,
    EPM_ACT_OFF   = 2'h1,
    EPM_ACT_ON    = 2'h2
  } epm_act_state_t;

endpackage : epm_pkg

// *** sim/epm_board.sv ***
/* board model: serial memory on the data line, pull-ups, leds, gpio drivers.
   assumes the pin drive ports of epm_pin_mux. */
module epm_board (
  // clock
  input logic clk,
  // eeprom pins
  input  logic eeprom_select_pin,
  input  logic eeprom_data_pin_o,
  input  logic eeprom_data_pin_oe,
  input  logic mem_bit,
  output logic eeprom_data_pin_i,
  input  logic strap_lo,
  input  logic eeprom_clock_pin_o,
  input  logic eeprom_clock_pin_oe,
  output logic eeprom_clock_pin_i,
  // gpio and led pins
  input  logic [2:0] gen_io_o,
  input  logic [2:0] gen_io_oe,
  input  logic [2:0] drv,
  input  logic [2:0] drv_en,
  output logic [2:0] gen_io_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_r = 1'b0;
  // no pull on the data line: a floating line toggles so it never looks valid
  always_comb eeprom_data_pin_i = eeprom_data_pin_oe ? eeprom_data_pin_o : eeprom_select_pin ? mem_bit : ~last_r;
  always_ff @(posedge clk) last_r <= eeprom_data_pin_i;
  // pull-up holds the strap high unless the bench straps it low
  always_comb eeprom_clock_pin_i = eeprom_clock_pin_oe ? eeprom_clock_pin_o : !strap_lo;
  // released led pins sit high through the led and its pull-up
  always_comb gen_io_i = (gen_io_oe & gen_io_o) | (~gen_io_oe & ~drv_en) | (~gen_io_oe & drv_en & drv);
endmodule : epm_board

// *** sim/epm_props.sv ***
/* assertions on the epm_pin_mux ports, bound below.
   assumes one clock and an async active-high reset. */
module epm_props #(
  parameter int unsigned LED_PULSE_CYC = 20
) (
  // clock and reset
  input logic clk,
  input logic rst,
  // roles and sources
  input epm_pkg::epm_role_t data_pin_role,
  input epm_pkg::epm_role_t clock_pin_role,
  input logic               general_out_a,
  input logic               mii_rx_clk,
  // eeprom pins
  input logic eeprom_select_pin,
  input logic eeprom_data_pin_o,
  input logic eeprom_data_pin_oe,
  input logic eeprom_clock_pin_o,
  input logic eeprom_clock_pin_oe,
  input logic eeprom_clock_pin_ie,
  // gpio and leds
  input logic [2:0]               gpio_led_sel,
  input epm_pkg::epm_phy_status_t phy_status,
  input logic [2:0]               gen_io_o,
  input logic [2:0]               gen_io_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       alt_d;
  logic       alt_c;
  logic [2:0] up_r;
  logic [2:0] up_nxt;
  assign alt_d = data_pin_role != epm_pkg::EPM_ROLE_EEPROM;
  assign alt_c = clock_pin_role != epm_pkg::EPM_ROLE_EEPROM;
  // released link led while linked: one dark pulse plus the output register at most
  logic [31:0] dark_r;
  logic [31:0] dark_nxt;
  always_comb dark_nxt = (gpio_led_sel[1] && phy_status.link_up && !gen_io_oe[1]) ? dark_r + 32'h1 : 32'h0;
  always_ff @(posedge clk or posedge rst) dark_r <= rst ? 32'h0 : dark_nxt;
  // saturating age since reset bounds the strap window
  always_comb up_nxt = (up_r == 3'h7) ? up_r : up_r + 3'h1;
  always_ff @(posedge clk or posedge rst) up_r <= rst ? 3'h0 : up_nxt;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sel_alt_a: assert property (alt_d || alt_c |=> !eeprom_select_pin)
    else $error("select active with alternate role");
  cs_first_a: assert property (eeprom_select_pin && alt_d |=> !eeprom_data_pin_oe)
    else $error("data pin driven before select dropped");
  gpo_out_a: assert property ((data_pin_role == epm_pkg::EPM_ROLE_GPO) [*2] |=>
    eeprom_data_pin_oe && eeprom_data_pin_o == $past(general_out_a)) else $error("data pin not general output");
  mon_clk_a: assert property ((clock_pin_role == epm_pkg::EPM_ROLE_MON_CLK) [*8] |=>
    eeprom_clock_pin_oe && eeprom_clock_pin_o == $past(mii_rx_clk)) else $error("clock pin not monitor");
  strap_ie_a: assert property (eeprom_clock_pin_ie |-> up_r < 3'h6 && !eeprom_clock_pin_oe)
    else $error("input buffer on outside strap window");
  speed_led_a: assert property (gpio_led_sel[0] |=>
    gen_io_oe[0] && gen_io_o[0] == $past(phy_status.speed_10 && phy_status.link_up)) else $error("speed led wrong");
  led_low_a: assert property (gpio_led_sel[1] |=> !(gen_io_oe[1] && gen_io_o[1]))
    else $error("link led driven high");
  dark_len_a: assert property (dark_r <= LED_PULSE_CYC + 1)
    else $error("link led dark too long");
  duplex_led_a: assert property (gpio_led_sel[2] |=> !(gen_io_oe[2] && gen_io_o[2]) &&
    gen_io_oe[2] == $past(phy_status.link_up && phy_status.full_duplex)) else $error("duplex led wrong");
  cover property (alt_d && eeprom_select_pin ##1 !eeprom_select_pin);
  cover property (alt_c && $rose(eeprom_clock_pin_oe));
  cover property (gpio_led_sel[1] && $fell(gen_io_oe[1]));
endmodule : epm_props

bind epm_pin_mux epm_props #(.LED_PULSE_CYC(LED_PULSE_CYC)) u_epm_props (.clk(clk), .rst(rst),
  .data_pin_role(data_pin_role), .clock_pin_role(clock_pin_role), .general_out_a(general_out_a),
  .mii_rx_clk(mii_rx_clk), .eeprom_select_pin(eeprom_select_pin), .eeprom_data_pin_o(eeprom_data_pin_o),
  .eeprom_data_pin_oe(eeprom_data_pin_oe), .eeprom_clock_pin_o(eeprom_clock_pin_o),
  .eeprom_clock_pin_oe(eeprom_clock_pin_oe), .eeprom_clock_pin_ie(eeprom_clock_pin_ie),
  .gpio_led_sel(gpio_led_sel), .phy_status(phy_status), .gen_io_o(gen_io_o), .gen_io_oe(gen_io_oe));

// *** sim/tb_top.sv ***
/* self-checking bench for epm_pin_mux.
   assumes epm_board on the far side and a shortened led pulse. */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned PULSE = 20;
  localparam int STEP [5] = '{2, PULSE - 5, 7, PULSE - 6, 7};
  localparam logic [4:0] LIT = 5'b01100;
  typedef struct {string s; int id; logic [7:0] v;} epm_note_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ee_select, ee_clock, ee_data_out, ee_data_oe, ee_data_in, general_out_a, general_out_b, mem_bit, strap_lo;
  logic mii_tx_en, mii_tx_clk, mii_rx_dv, mii_rx_clk, crossover_strap, crossover_enable, clock_strap_level;
  logic eeprom_select_pin, eeprom_data_pin_o, eeprom_data_pin_oe, eeprom_data_pin_i;
  logic eeprom_clock_pin_o, eeprom_clock_pin_oe, eeprom_clock_pin_ie, eeprom_clock_pin_i;
  logic [2:0] gpio_led_sel, gpio_out, gpio_irq_pol, gpio_in, gpio_irq_event, gen_io_o, gen_io_oe, gen_io_i, drv, drv_en;
  epm_pkg::epm_role_t data_pin_role, clock_pin_role;
  epm_pkg::epm_gpio_mode_t gpio_mode [3];
  epm_pkg::epm_phy_status_t phy_status;
  logic [31:0] seed = 32'h63d6;
  logic [7:0] irq_cnt;
  logic [13:0] seen;
  int n_mismatch = 0;
  int total_checks = 0;
  int cyc = 0;
  epm_note_t exp_q [$];
  event look;
  assign seen = {ee_data_in, clock_strap_level, crossover_enable, eeprom_clock_pin_ie, gen_io_oe, gen_io_o[0],
    gpio_in[0], eeprom_select_pin, eeprom_data_pin_o, eeprom_data_pin_oe, eeprom_clock_pin_o, eeprom_clock_pin_oe};
  epm_pin_mux #(.LED_PULSE_CYC(PULSE)) u_epm_pin_mux (.clk, .rst, .ee_select, .ee_clock, .ee_data_out, .ee_data_oe,
    .ee_data_in, .data_pin_role, .clock_pin_role, .general_out_a, .general_out_b, .mii_tx_en, .mii_tx_clk,
    .mii_rx_dv, .mii_rx_clk, .eeprom_select_pin, .eeprom_data_pin_o, .eeprom_data_pin_oe, .eeprom_data_pin_i,
    .eeprom_clock_pin_o, .eeprom_clock_pin_oe, .eeprom_clock_pin_ie, .eeprom_clock_pin_i, .clock_strap_level,
    .gpio_led_sel, .gpio_mode, .gpio_out, .gpio_irq_pol, .gpio_in, .gpio_irq_event, .phy_status, .gen_io_o,
    .gen_io_oe, .gen_io_i, .crossover_strap, .crossover_enable);
  epm_board u_epm_board (.clk, .eeprom_select_pin, .eeprom_data_pin_o, .eeprom_data_pin_oe, .mem_bit,
    .eeprom_data_pin_i, .strap_lo, .eeprom_clock_pin_o, .eeprom_clock_pin_oe, .eeprom_clock_pin_i, .gen_io_o, .gen_io_oe,
    .drv, .drv_en, .gen_io_i);
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic tick(int n);
    repeat (n) @(negedge clk);
  endtask : tick
  task automatic want(string s, int id, logic [7:0] v);
    exp_q.push_back('{s, id, v});
  endtask : want
  // one nanosecond lets the monitor drain the queue before inputs move
  task automatic check_now;
    -> look;
    #1;
  endtask : check_now
  task automatic cmp(string s, logic [7:0] e, logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask : cmp
  task automatic finish_test;
    if (n_mismatch == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      finish_test();
    end
  end
  initial begin : monitor
    epm_note_t n;
    forever begin
      @(look);
      while (exp_q.size() > 0) begin
        n = exp_q.pop_front();
        cmp(n.s, n.v, (n.id < 14) ? {7'h0, seen[n.id]} : irq_cnt);
      end
    end
  end
  initial begin
    {ee_select, ee_clock, ee_data_out, ee_data_oe, general_out_a, general_out_b, mem_bit, strap_lo} = '0;
    {mii_tx_en, mii_tx_clk, mii_rx_dv, mii_rx_clk, gpio_led_sel, gpio_out, gpio_irq_pol, drv, drv_en} = '0;
    data_pin_role = epm_pkg::EPM_ROLE_EEPROM;
    clock_pin_role = epm_pkg::EPM_ROLE_EEPROM;
    gpio_mode = '{default: epm_pkg::EPM_GPIO_INPUT};
    phy_status = '0;
    crossover_strap = 1'b1;
    repeat (5) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    tick(8);
    want("strap", 12, 8'h1);
    want("clk_ie", 10, 8'h0);
    want("xover", 11, 8'h1);
    check_now();
    {ee_select, ee_data_oe, ee_data_out} = 3'h7;
    tick(1);
    want("select", 4, 8'h1);
    want("data_o", 3, 8'h1);
    want("data_oe", 2, 8'h1);
    check_now();
    ee_data_oe = 1'b0;
    for (int b = 0; b < 2; b++) begin
      mem_bit = b[0];
      tick(7);
      want("data_in", 13, {7'h0, b[0]});
      check_now();
    end
    for (int p = 0; p < 2; p++) begin
      for (int r = 1; r < 4; r++) begin
        data_pin_role = epm_pkg::EPM_ROLE_EEPROM;
        clock_pin_role = epm_pkg::EPM_ROLE_EEPROM;
        ee_select = 1'b1;
        tick(2);
        seed = lfsr(seed);
        {ee_clock, mii_rx_clk, mii_tx_clk, mii_rx_dv, mii_tx_en, general_out_b, general_out_a} = seed[6:0];
        if (p == 0) data_pin_role = epm_pkg::epm_role_t'(r);
        else clock_pin_role = epm_pkg::epm_role_t'(r);
        tick(1);
        want("select", 4, 8'h0);
        want("pin_oe", 2 - 2 * p, 8'h0);
        check_now();
        tick(1);
        want("pin_oe", 2 - 2 * p, 8'h1);
        want("pin_o", 3 - 2 * p, {7'h0, seed[2 * r - 2 + p]});
        check_now();
      end
    end
    for (int m = 1; m < 3; m++) begin
      seed = lfsr(seed);
      gpio_out = seed[2:0];
      gpio_mode = '{default: epm_pkg::epm_gpio_mode_t'(m)};
      tick(1);
      for (int k = 0; k < 3; k++) want("gpio_oe", 7 + k, {7'h0, m == 1 || !seed[k]});
      if (m == 1) want("gpio_o", 6, {7'h0, seed[0]});
      check_now();
    end
    gpio_mode = '{default: epm_pkg::EPM_GPIO_INPUT};
    drv_en = 3'h7;
    for (int pol = 0; pol < 2; pol++) begin
      gpio_irq_pol = {3{pol[0]}};
      drv = {3{~pol[0]}};
      tick(6);
      want("gpio_in", 5, {7'h0, ~pol[0]});
      check_now();
      drv = {3{pol[0]}};
      irq_cnt = 8'h0;
      repeat (8) begin
        tick(1);
        irq_cnt = irq_cnt + {7'h0, gpio_irq_event[0]};
      end
      want("irq_pulses", 14, 8'h1);
      check_now();
    end
    drv_en = 3'h0;
    gpio_led_sel = 3'h7;
    for (int s = 0; s < 16; s++) begin
      phy_status = s[3:0] & 4'hd;
      tick(1);
      want("speed_o", 6, {7'h0, s[3] & s[2]});
      want("link_oe", 8, {7'h0, s[2]});
      want("duplex_oe", 9, {7'h0, s[2] & s[0]});
      check_now();
    end
    phy_status = 4'h6;
    for (int i = 0; i < 5; i++) begin
      tick(STEP[i]);
      want("link_oe", 8, {7'h0, LIT[i]});
      check_now();
    end
    for (int x = 0; x < 2; x++) begin
      crossover_strap = x[0];
      tick(6);
      want("xover", 11, {7'h0, x[0]});
      check_now();
    end
    // second reset with the strap pulled low: the window must catch it
    strap_lo = 1'b1;
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    tick(1);
    want("clk_ie", 10, 8'h1);
    want("clk_oe", 0, 8'h0);
    check_now();
    tick(7);
    want("strap", 12, 8'h0);
    want("clk_ie", 10, 8'h0);
    want("clk_oe", 0, 8'h1);
    check_now();
    finish_test();
  end
endmodule : tb_top

// *** src/epm_pin_mux.sv ***
/*
  shared-pin multiplexer: eeprom pins, general outputs, mii monitors,
  three gpio/led pins, crossover strap and power-up strap capture.
  assumes the surrounding controller provides the eeprom engine signals,
  the internal mii signals and the phy status on clk.
*/
// Contract
// - eeprom data pin drives and samples bidirectionally for the external eeprom.
// - chip select held inactive whenever an eeprom pin takes an alternate role.
// - data pin may be general output, tx enable monitor or tx clock monitor.
// - clock pin may be general output, rx valid monitor or rx clock monitor.
// - clock pin level captured at power-up; its input buffer enabled only then.
// - each gpio is input, push-pull or open-drain per configuration.
// - speed led low at 100M, negotiating or no cable; high only at 10M.
// - link/activity led low while a valid link is present.
// - on activity pulse high 80 ms, then low at least 80 ms, repeating.
// - duplex led low in full duplex, released otherwise; the code also releases it whenever link_up is low.
// - crossover enabled when strap high or open, disabled when pulled low.
// - gpio inputs raise interrupts with per-pin selectable polarity.
// - the two general-output-only pins never raise interrupts.
`include "epm_params.svh"
module epm_pin_mux #(
  parameter int unsigned LED_PULSE_CYC = `EPM_LED_PULSE_CYC
) (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // eeprom engine side
  input  wire logic                   ee_select,
  input  wire logic                   ee_clock,
  input  wire logic                   ee_data_out,
  input  wire logic                   ee_data_oe,
  output logic                        ee_data_in,
  // role selection and general outputs
  input  wire epm_pkg::epm_role_t     data_pin_role,
  input  wire epm_pkg::epm_role_t     clock_pin_role,
  input  wire logic                   general_out_a,
  input  wire logic                   general_out_b,
  // internal mii signals to monitor
  input  wire logic                   mii_tx_en,
  input  wire logic                   mii_tx_clk,
  input  wire logic                   mii_rx_dv,
  input  wire logic                   mii_rx_clk,
  // eeprom pins
  output logic                        eeprom_select_pin,
  output logic                        eeprom_data_pin_o,
  output logic                        eeprom_data_pin_oe,
  input  wire logic                   eeprom_data_pin_i,
  output logic                        eeprom_clock_pin_o,
  output logic                        eeprom_clock_pin_oe,
  output logic                        eeprom_clock_pin_ie,
  input  wire logic                   eeprom_clock_pin_i,
  output logic                        clock_strap_level,
  // gpio configuration
  input  wire logic [2:0]             gpio_led_sel,
  input  wire epm_pkg::epm_gpio_mode_t gpio_mode [3],
  input  wire logic [2:0]             gpio_out,
  input  wire logic [2:0]             gpio_irq_pol,
  output logic [2:0]                  gpio_in,
  output logic [2:0]                  gpio_irq_event,
  // phy status
  input  wire epm_pkg::epm_phy_status_t phy_status,
  // gpio/led pins
  output logic [2:0]                  gen_io_o,
  output logic [2:0]                  gen_io_oe,
  input  wire logic [2:0]             gen_io_i,
  // crossover strap
  input  wire logic                   crossover_strap,
  output logic                        crossover_enable
);

  if (LED_PULSE_CYC < 2) begin : g_bad_pulse
    $error("LED_PULSE_CYC too small");
  end

  // pin synchronisers: three stages, change counts when stages 2 and 3 agree
  logic [2:0] gio_s1_r, gio_s2_r, gio_s3_r, gio_q_r, gio_q_nxt;
  logic [2:0] xs_r, xs_nxt;
  logic [2:0] eds_r, eds_nxt;
  logic [2:0] gio_s1_nxt, gio_s2_nxt, gio_s3_nxt;
  logic       xo_r, xo_nxt;

  always_comb begin
    gio_s1_nxt = gen_io_i;
    gio_s2_nxt = gio_s1_r;
    gio_s3_nxt = gio_s2_r;
    gio_q_nxt  = gio_q_r;
    for (int i = 0; i < 3; i++) begin
      if (gio_s2_r[i] == gio_s3_r[i]) gio_q_nxt[i] = gio_s3_r[i];
    end
    xs_nxt  = {xs_r[1:0], crossover_strap};
    xo_nxt  = (xs_r[1] == xs_r[2]) ? xs_r[2] : xo_r;
    eds_nxt = {eds_r[1:0], eeprom_data_pin_i};
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gio_s1_r <= 3'h0;
      gio_s2_r <= 3'h0;
      gio_s3_r <= 3'h0;
      gio_q_r  <= 3'h0;
      xs_r     <= 3'h7;
      xo_r     <= 1'h1;
      eds_r    <= 3'h0;
    end else begin
      gio_s1_r <= gio_s1_nxt;
      gio_s2_r <= gio_s2_nxt;
      gio_s3_r <= gio_s3_nxt;
      gio_q_r  <= gio_q_nxt;
      xs_r     <= xs_nxt;
      xo_r     <= xo_nxt;
      eds_r    <= eds_nxt;
    end
  end

  // power-up strap capture on the eeprom clock pin
  logic       strap_win_r, strap_win_nxt;
  logic [2:0] cks_r, cks_nxt;
  logic       strap_r, strap_nxt;
  logic [1:0] strap_cnt_r, strap_cnt_nxt;

  always_comb begin
    cks_nxt       = {cks_r[1:0], eeprom_clock_pin_i};
    strap_nxt     = strap_r;
    strap_win_nxt = strap_win_r;
    strap_cnt_nxt = strap_cnt_r;
    if (strap_win_r) begin
      // window spans the synchroniser depth after reset release
      if (cks_r[1] == cks_r[2]) strap_nxt = cks_r[2];
      strap_cnt_nxt = strap_cnt_r + 2'h1;
      if (strap_cnt_r == 2'h3) strap_win_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cks_r       <= 3'h7;
      strap_r     <= 1'h1;
      strap_win_r <= 1'h1;
      strap_cnt_r <= 2'h0;
    end else begin
      cks_r       <= cks_nxt;
      strap_r     <= strap_nxt;
      strap_win_r <= strap_win_nxt;
      strap_cnt_r <= strap_cnt_nxt;
    end
  end

  // activity blinker
  epm_pkg::epm_act_state_t act_st_r, act_st_nxt;
  logic [31:0]             act_cnt_r, act_cnt_nxt;
  logic                    act_dark;

  always_comb begin
    act_st_nxt  = act_st_r;
    act_cnt_nxt = act_cnt_r;
    unique case (act_st_r)
      epm_pkg::EPM_ACT_IDLE: begin
        if (phy_status.activity) begin
          act_st_nxt  = epm_pkg::EPM_ACT_OFF;
          act_cnt_nxt = 32'h0;
        end
      end
      epm_pkg::EPM_ACT_OFF: begin
        act_cnt_nxt = act_cnt_r + 32'h1;
        if (act_cnt_r == LED_PULSE_CYC - 1) begin
          act_st_nxt  = epm_pkg::EPM_ACT_ON;
          act_cnt_nxt = 32'h0;
        end
      end
      epm_pkg::EPM_ACT_ON: begin
        act_cnt_nxt = act_cnt_r + 32'h1;
        if (act_cnt_r == LED_PULSE_CYC - 1) begin
          act_st_nxt  = epm_pkg::EPM_ACT_IDLE;
          act_cnt_nxt = 32'h0;
        end
      end
      default: begin
        act_st_nxt  = epm_pkg::EPM_ACT_IDLE;
        act_cnt_nxt = 32'h0;
      end
    endcase
    act_dark = (act_st_r == epm_pkg::EPM_ACT_OFF);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      act_st_r  <= epm_pkg::EPM_ACT_IDLE;
      act_cnt_r <= 32'h0;
    end else begin
      act_st_r  <= act_st_nxt;
      act_cnt_r <= act_cnt_nxt;
    end
  end

  // pin drive
  epm_pkg::epm_pin_drive_t dp_nxt, cp_nxt;
  logic                    sel_nxt, ein_nxt, arm_nxt;
  logic [2:0]              led_low, gio_o_nxt, gio_oe_nxt, irq_nxt;
  logic [2:0]              irq_lvl_r, irq_lvl_nxt;
  epm_pkg::epm_pin_drive_t dp_r, cp_r;
  logic                    sel_r, ein_r, arm_r;
  logic [2:0]              gio_o_r, gio_oe_r, irq_r;

  always_comb begin
    // select follows only when both pins are eeprom role, registered with them
    sel_nxt = (data_pin_role == epm_pkg::EPM_ROLE_EEPROM) &&
              (clock_pin_role == epm_pkg::EPM_ROLE_EEPROM) && ee_select;
    unique case (data_pin_role)
      epm_pkg::EPM_ROLE_EEPROM:   dp_nxt = '{o: ee_data_out, oe: ee_data_oe};
      epm_pkg::EPM_ROLE_GPO:      dp_nxt = '{o: general_out_a, oe: 1'b1};
      epm_pkg::EPM_ROLE_MON_CTRL: dp_nxt = '{o: mii_tx_en, oe: 1'b1};
      epm_pkg::EPM_ROLE_MON_CLK:  dp_nxt = '{o: mii_tx_clk, oe: 1'b1};
    endcase
    unique case (clock_pin_role)
      epm_pkg::EPM_ROLE_EEPROM:   cp_nxt = '{o: ee_clock, oe: 1'b1};
      epm_pkg::EPM_ROLE_GPO:      cp_nxt = '{o: general_out_b, oe: 1'b1};
      epm_pkg::EPM_ROLE_MON_CTRL: cp_nxt = '{o: mii_rx_dv, oe: 1'b1};
      epm_pkg::EPM_ROLE_MON_CLK:  cp_nxt = '{o: mii_rx_clk, oe: 1'b1};
    endcase
    // alternate output waits one cycle so select is already low when it drives
    if (sel_r && (data_pin_role != epm_pkg::EPM_ROLE_EEPROM)) dp_nxt.oe = 1'b0;
    if (sel_r && (clock_pin_role != epm_pkg::EPM_ROLE_EEPROM)) cp_nxt.oe = 1'b0;
    if (strap_win_r) cp_nxt.oe = 1'b0;

    led_low[0] = !phy_status.speed_10 || !phy_status.link_up;
    led_low[1] = phy_status.link_up && !act_dark;
    led_low[2] = phy_status.link_up && phy_status.full_duplex;
    for (int i = 0; i < 3; i++) begin
      if (gpio_led_sel[i]) begin
        gio_o_nxt[i]  = 1'b0;
        gio_oe_nxt[i] = (i == 0) ? 1'b1 : led_low[i];
        if (i == 0) gio_o_nxt[i] = !led_low[0];
      end else begin
        unique case (gpio_mode[i])
          epm_pkg::EPM_GPIO_PUSHPULL: begin
            gio_o_nxt[i]  = gpio_out[i];
            gio_oe_nxt[i] = 1'b1;
          end
          epm_pkg::EPM_GPIO_OPENDRAIN: begin
            gio_o_nxt[i]  = 1'b0;
            gio_oe_nxt[i] = !gpio_out[i];
          end
          default: begin
            gio_o_nxt[i]  = 1'b0;
            gio_oe_nxt[i] = 1'b0;
          end
        endcase
      end
      // interrupt on entering the active level; general outputs have none
      irq_nxt[i] = arm_r && !gpio_led_sel[i] && (gpio_mode[i] == epm_pkg::EPM_GPIO_INPUT) &&
                   ((gio_q_r[i] ^ !gpio_irq_pol[i]) && !irq_lvl_r[i]);
    end
    // synchroniser still shows its reset value inside the strap window: no false event
    arm_nxt     = !strap_win_r;
    irq_lvl_nxt = gio_q_r ^ ~gpio_irq_pol;
    ein_nxt     = (eds_r[1] == eds_r[2]) ? eds_r[2] : ein_r;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sel_r     <= 1'b0;
      dp_r      <= '0;
      cp_r      <= '0;
      ein_r     <= 1'b0;
      gio_o_r   <= 3'h0;
      gio_oe_r  <= 3'h0;
      irq_r     <= 3'h0;
      irq_lvl_r <= 3'h0;
      arm_r     <= 1'b0;
    end else begin
      sel_r     <= sel_nxt;
      dp_r      <= dp_nxt;
      cp_r      <= cp_nxt;
      ein_r     <= ein_nxt;
      gio_o_r   <= gio_o_nxt;
      gio_oe_r  <= gio_oe_nxt;
      irq_r     <= irq_nxt;
      irq_lvl_r <= irq_lvl_nxt;
      arm_r     <= arm_nxt;
    end
  end

  assign eeprom_select_pin   = sel_r;
  assign eeprom_data_pin_o   = dp_r.o;
  assign eeprom_data_pin_oe  = dp_r.oe;
  assign eeprom_clock_pin_o  = cp_r.o;
  assign eeprom_clock_pin_oe = cp_r.oe;
  assign eeprom_clock_pin_ie = strap_win_r;
  assign clock_strap_level   = strap_r;
  assign ee_data_in          = ein_r;
  assign gen_io_o            = gio_o_r;
  assign gen_io_oe           = gio_oe_r;
  assign gpio_in             = gio_q_r;
  assign gpio_irq_event      = irq_r;
  assign crossover_enable    = xo_r;

endmodule : epm_pin_mux
